// ### tcr_regbank.sv
// Host-visible control register bank of the timing chip.
// Assumes the serial processor port engine hands over one word-level
// read or write per strobe, on clk, and that pin inputs are asynchronous.
//
// Behaviour
// - Writes to read-only fields change nothing.
// - Self-clearing bit returns to zero after action.
// - Latch-high bit sets on event, clears on read.
// - Latch-low bit clears on event, sets on read.
// - Signature holds revision and device code.
// - Bit 15 of control A fires global reset.
// - Control A holds five 3-bit pin modes.
// - Bidir pin 1 mode straps from output pin.
// - Control B holds modes for pins 7..4.
// - Bit 13 selects edge for pins 4..7.
// - Bit 12 selects edge for pins 1..3.
// - Pin latched status sets on edge, read-clears.
module tcr_regbank
  import tcr_pkg::*;
#(
  parameter logic [3:0]  SILICON_REV = 4'h1,   // Arbitrary value.
  parameter logic [11:0] DEVICE_CODE = 12'h5a5, // Arbitrary value.
  parameter logic [NUM_PINS-1:0] LATCH_LOW_MASK = '0
) (
  // Clock and reset.
  input  wire logic                clk,
  input  wire logic                reset_n,
  // Host transaction port.
  input  wire logic                reg_rd,
  input  wire logic                reg_wr,
  input  wire logic [ADDR_W-1:0]   reg_addr,
  input  wire logic [DATA_W-1:0]   reg_wdata,
  output logic      [DATA_W-1:0]   reg_rdata,
  output logic                     reg_rvalid,
  // Pin levels and strap.
  input  wire logic [NUM_PINS-1:0] pin_in,
  input  wire logic                out_pin_a_strap,
  // Configuration and reset to the rest of the device.
  output tcr_cfg_t                 pin_cfg,
  output logic                     soft_reset
);

  // Elaboration check: the status word has room for exactly seven pins,
  // split three and four between the two edge groups.
  if (NUM_PINS != 7 || LOWER_PINS != 3) begin : g_bad_pins
    $error("tcr_regbank: pin groups do not fit the status word");
  end

  // Address decode, all plain named wires.
  // Write strobes and the status read are qualified here; the plain read strobe goes to the memory and read pipeline unqualified.
  wire logic hit_sig   = (reg_addr == ADDR_PART_SIG);
  wire logic hit_a     = (reg_addr == ADDR_CTRL_A);
  wire logic hit_b     = (reg_addr == ADDR_CTRL_B);
  wire logic hit_stat  = (reg_addr == ADDR_PIN_STAT);
  wire logic hit_ext   = EXT_RW_MAP[reg_addr];
  wire logic wr_a      = reg_wr && hit_a;
  wire logic wr_b      = reg_wr && hit_b;
  wire logic wr_ext    = reg_wr && hit_ext;
  wire logic rd_stat   = reg_rd && hit_stat;

  // Incoming words seen as control fields.
  wire tcr_ctrl_a_t wd_a = reg_wdata;
  wire tcr_ctrl_b_t wd_b = reg_wdata;

  // Pin synchronisers: two flops, then a third stage for edge detection.
  logic [NUM_PINS-1:0] pin_s1_reg;   // First stage, read only by stage 2.
  logic [NUM_PINS-1:0] pin_s2_reg;   // Settled live level.
  logic [NUM_PINS-1:0] pin_s3_reg;   // Previous settled level.
  logic [NUM_PINS-1:0] pin_event;    // Selected edge, one-cycle pulse.
  logic [NUM_PINS-1:0] lat_act_reg;  // Event seen since last read.
  logic [NUM_PINS-1:0] lat_act_next;

  // Strap synchroniser and capture.
  logic       strap_s1_reg;          // First stage, read only by stage 2.
  logic       strap_s2_reg;
  logic       strap_val_reg;         // Strap level kept for soft resets.
  logic [1:0] strap_cnt_reg;         // Counts settle time after release.
  wire  logic strap_take = (strap_cnt_reg == STRAP_WAIT - 2'h1);

  // Control words and the self-clearing reset pulse.
  tcr_cfg_t   cfg_reg;
  tcr_cfg_t   cfg_next;
  logic       soft_reset_reg;
  wire  logic soft_fire = wr_a && wd_a.soft_rst;

  // Read pipeline state.
  logic [DATA_W-1:0] local_q_reg;    // Bank-owned word captured at take.
  logic              ext_sel_reg;    // Answer comes from the memory.
  logic              rd_d1_reg;
  logic [DATA_W-1:0] rdata_reg;
  logic              rvalid_reg;
  logic [DATA_W-1:0] mem_q;

  // Both synchronisers; the first stage feeds nothing but the second.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pin_s1_reg   <= '0;
      pin_s2_reg   <= '0;
      pin_s3_reg   <= '0;
      strap_s1_reg <= 1'b0;
      strap_s2_reg <= 1'b0;
    end else begin
      pin_s1_reg   <= pin_in;
      pin_s2_reg   <= pin_s1_reg;
      pin_s3_reg   <= pin_s2_reg;
      strap_s1_reg <= out_pin_a_strap;
      strap_s2_reg <= strap_s1_reg;
    end
  end

  // Edge pick per pin: lower group by one bit, upper group by another.
  for (genvar i = 0; i < NUM_PINS; i++) begin : g_pin
    wire logic rise = pin_s2_reg[i] && !pin_s3_reg[i];
    wire logic fall = !pin_s2_reg[i] && pin_s3_reg[i];
    wire logic sel  = (i < LOWER_PINS) ?
                      cfg_reg.b.lower_pins_latch_edge :
                      cfg_reg.b.upper_pins_latch_edge;
    assign pin_event[i] = sel ? rise : fall;
  end

  // Event latch: a new event beats the read that would clear it.
  // Stored as "event seen"; latch-low bits are inverted on the read path.
  assign lat_act_next = pin_event |
                        (lat_act_reg & {NUM_PINS{!rd_stat}});

  // A global reset clears every latched event, a new one included.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      lat_act_reg <= '0;
    end else if (soft_reset_reg) begin
      lat_act_reg <= '0;
    end else begin
      lat_act_reg <= lat_act_next;
    end
  end

  // Strap is taken once the synchroniser has settled after release,
  // because an asynchronous reset may only load constants.
  // The kept copy serves later global resets, which sample no strap.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      strap_cnt_reg <= 2'h0;
      strap_val_reg <= 1'b0;
    end else if (strap_cnt_reg != STRAP_WAIT) begin
      strap_cnt_reg <= strap_cnt_reg + 2'h1;
      strap_val_reg <= strap_s2_reg;
    end
  end

  // Next value of the control words.
  // The soft reset bit is never stored, so it always reads as zero.
  // Host writes land in the strap cycle too; only the pin 1 mode field
  // is then taken from the strap, so no other setting is lost.
  always_comb begin
    cfg_next = cfg_reg;
    if (soft_reset_reg) begin
      cfg_next.a = CTRL_A_RST;
      cfg_next.b = CTRL_B_RST;
      cfg_next.a.bidir_pin_1_mode =
        strap_val_reg ? MODE_CLK125 : MODE_HIZ;
    end else begin
      if (wr_a) begin
        cfg_next.a = wd_a;
        cfg_next.a.soft_rst = 1'b0;
      end
      if (wr_b) begin
        cfg_next.b = wd_b;
        cfg_next.b.rsvd = 2'h0;
      end
      if (strap_take) begin
        cfg_next.a.bidir_pin_1_mode =
          strap_s2_reg ? MODE_CLK125 : MODE_HIZ;
      end
    end
  end

  // Control words and the reset pulse.
  // The pulse lasts one cycle and clears the bank a cycle later.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cfg_reg        <= {CTRL_A_RST, CTRL_B_RST};
      soft_reset_reg <= 1'b0;
    end else begin
      cfg_reg        <= cfg_next;
      soft_reset_reg <= soft_fire;
    end
  end

  // Memory for the plain words; read-only addresses never write it, but every read goes to it.
  tcr_word_mem #(
    .DW (DATA_W),
    .AW (ADDR_W)
  ) u_mem (
    .clk       (clk),
    .we        (wr_ext),
    .waddr     (reg_addr),
    .wdata     (reg_wdata),
    .re        (reg_rd),
    .raddr     (reg_addr),
    .rdata_reg (mem_q)
  );

  // Words owned by the bank, as seen at the take edge.
  wire logic [DATA_W-1:0] sig_word  = {SILICON_REV, DEVICE_CODE};
  wire logic [DATA_W-1:0] stat_word = {
    1'b0, lat_act_reg ^ LATCH_LOW_MASK,
    1'b0, pin_s2_reg};
  wire logic [DATA_W-1:0] local_word =
    hit_sig  ? sig_word :
    hit_a    ? DATA_W'(cfg_reg.a) :
    hit_b    ? DATA_W'(cfg_reg.b) :
    hit_stat ? stat_word : '0;                           // unmapped reads 0

  // Read pipeline: take, then answer two edges later.
  // The memory's own output flop lines up with the local capture flop.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      local_q_reg <= '0;
      ext_sel_reg <= 1'b0;
      rd_d1_reg   <= 1'b0;
      rdata_reg   <= '0;
      rvalid_reg  <= 1'b0;
    end else begin
      rd_d1_reg  <= reg_rd;
      rvalid_reg <= rd_d1_reg;
      if (reg_rd) begin
        local_q_reg <= local_word;
        ext_sel_reg <= hit_ext;
      end
      if (rd_d1_reg) begin
        rdata_reg <= ext_sel_reg ? mem_q : local_q_reg;
      end
    end
  end

  // Outputs straight from flops.
  assign reg_rdata  = rdata_reg;
  assign reg_rvalid = rvalid_reg;
  assign pin_cfg    = cfg_reg;
  assign soft_reset = soft_reset_reg;

  // Checks.
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  // Helper: address pipeline for read checks.
  logic [ADDR_W-1:0] chk_addr_d1;
  logic [ADDR_W-1:0] chk_addr_d2;
  always_ff @(posedge clk) begin
    chk_addr_d1 <= reg_addr;
    chk_addr_d2 <= chk_addr_d1;
  end

  // Read path checks.
  // Back-to-back reads are legal, so the answer marker of an earlier read
  // may stand at the take edge; latency and origin are checked apart.
  rd_latency_a: assert property (
    reg_rd |-> ##2 reg_rvalid)
    else $error("read answer not two cycles after take");

  rvalid_src_a: assert property (
    reg_rvalid |-> $past(reg_rd, 2))
    else $error("read answer without a read two cycles before");

  // Control, signature and read-only word checks.
  // A second reset write right behind the first may stretch the pulse.
  sc_pulse_a: assert property (
    soft_fire |=> soft_reset ##1 (!soft_reset || $past(soft_fire)))
    else $error("soft reset pulse wrong");

  sc_readback_a: assert property (
    reg_rvalid && chk_addr_d2 == ADDR_CTRL_A && $past(reg_rd, 2)
      |-> !reg_rdata[SOFT_RST_POS])
    else $error("self-clearing bit read as one");

  sig_value_a: assert property (
    reg_rvalid && chk_addr_d2 == ADDR_PART_SIG && $past(reg_rd, 2)
      |-> reg_rdata == {SILICON_REV, DEVICE_CODE})
    else $error("signature word wrong");

  ro_write_a: assert property (
    reg_wr && (hit_stat || hit_sig) && !reg_rd && !soft_reset
      && !strap_take && pin_event == '0
      |=> $stable(lat_act_reg) && $stable(cfg_reg))
    else $error("write to read-only word changed state");

  // Latched status, control write, strap and global reset checks.
  latch_set_a: assert property (
    pin_event != '0 && !soft_reset
      |=> (lat_act_reg & $past(pin_event)) == $past(pin_event))
    else $error("latched status missed an event");

  latch_clear_a: assert property (
    rd_stat && pin_event == '0 && !soft_reset |=> lat_act_reg == '0)
    else $error("read did not clear latched status");

  wrong_edge_a: assert property (
    !cfg_reg.b.lower_pins_latch_edge && !lat_act_reg[0]
      && pin_s2_reg[0] && !pin_s3_reg[0] && !soft_reset
      |=> !lat_act_reg[0])
    else $error("rising edge latched while falling selected");

  ctrl_b_write_a: assert property (
    wr_b && !soft_reset
      |=> cfg_reg.b == {2'h0, $past(reg_wdata[13:0])})
    else $error("control B write not stored");

  strap_load_a: assert property (
    strap_take && !soft_reset |=> cfg_reg.a.bidir_pin_1_mode ==
      ($past(strap_s2_reg) ? MODE_CLK125 : MODE_HIZ))
    else $error("strap did not set pin 1 mode");

  ctrl_a_write_a: assert property (
    wr_a && !soft_reset && !strap_take
      |=> cfg_reg.a == {1'b0, $past(reg_wdata[14:0])})
    else $error("control A write not stored");

  soft_clear_a: assert property (
    soft_reset |=> cfg_reg.b == CTRL_B_RST && lat_act_reg == '0)
    else $error("global reset left control B or status set");

  latch_hold_a: assert property (
    !rd_stat && !soft_reset
      |=> (lat_act_reg & $past(lat_act_reg)) == $past(lat_act_reg))
    else $error("latched status lost without a read");

  wrong_edge_up_a: assert property (
    cfg_reg.b.upper_pins_latch_edge && !lat_act_reg[LOWER_PINS+1]
      && !pin_s2_reg[LOWER_PINS+1] && pin_s3_reg[LOWER_PINS+1]
      && !soft_reset |=> !lat_act_reg[LOWER_PINS+1])
    else $error("falling edge latched while rising selected");

  // Scenario covers.
  rd_stat_c: cover property (rd_stat && lat_act_reg != '0);
  soft_rst_c: cover property (soft_fire);
  ext_rw_c: cover property (wr_ext ##1 reg_rd && hit_ext);
  upper_edge_c: cover property (
    cfg_reg.b.upper_pins_latch_edge && pin_event[NUM_PINS-1]);
  strap_low_c: cover property (strap_take && !strap_s2_reg);

endmodule : tcr_regbank

// ### tcr_pkg.sv
// Shared constants and types for the timing chip control register bank.
// Assumes a 16-bit word-addressed host port in front of the bank.
package tcr_pkg;

  // Host port geometry.
  localparam int ADDR_W = 5;
  localparam int DATA_W = 16;

  // Word offsets of the register map.
  localparam logic [4:0] ADDR_PART_SIG  = 5'h00;
  localparam logic [4:0] ADDR_CTRL_A    = 5'h01;
  localparam logic [4:0] ADDR_CTRL_B    = 5'h02;
  localparam logic [4:0] ADDR_PIN_STAT  = 5'h03;
  localparam logic [4:0] ADDR_EV_LATCH  = 5'h04;
  localparam logic [4:0] ADDR_EV_MASK   = 5'h05;
  localparam logic [4:0] ADDR_EV_LIVE   = 5'h06;
  localparam logic [4:0] ADDR_TE_W1     = 5'h09;
  localparam logic [4:0] ADDR_TE_W2     = 5'h0a;
  localparam logic [4:0] ADDR_TE_W3     = 5'h0b;
  localparam logic [4:0] ADDR_TE_W4     = 5'h0c;
  localparam logic [4:0] ADDR_TE_W5     = 5'h0d;
  localparam logic [4:0] ADDR_TE_CMD    = 5'h0e;
  localparam logic [4:0] ADDR_CORE_CFG1 = 5'h10;
  localparam logic [4:0] ADDR_CORE_CFG2 = 5'h11;
  localparam logic [4:0] ADDR_STAMP_CFG = 5'h12;
  localparam logic [4:0] ADDR_PULSE_CFG = 5'h13;
  localparam logic [4:0] ADDR_STAMP_DIV = 5'h14;
  localparam logic [4:0] ADDR_CORE_CFG3 = 5'h1a;

  // One bit per address for the plain read-write words kept in memory.
  localparam logic [31:0] EXT_RW_MAP = 32'h0417_7e20;

  // Field positions inside the control and status words.
  localparam int SOFT_RST_POS   = 15;
  localparam int STAT_LATCH_LSB = 8;
  localparam int STAT_LIVE_LSB  = 0;

  // Pin counts: pins 1..3 form the lower edge group.
  localparam int NUM_PINS   = 7;
  localparam int LOWER_PINS = 3;

  // Pin mode encodings used at reset.
  localparam logic [2:0] MODE_HIZ    = 3'h0;
  localparam logic [2:0] MODE_CLK125 = 3'h4;

  // Read answer latency in clock cycles.
  localparam int RD_LAT = 2;

  // Cycles from reset release until the strap sample is taken.
  localparam logic [1:0] STRAP_WAIT = 2'h3;

  // First pin-function control word, bit 15 down to bit 0.
  typedef struct packed {
    logic       soft_rst;
    logic [2:0] out_pin_a_mode;
    logic [2:0] out_pin_b_mode;
    logic [2:0] bidir_pin_1_mode;
    logic [2:0] bidir_pin_2_mode;
    logic [2:0] bidir_pin_3_mode;
  } tcr_ctrl_a_t;

  // Second pin-function control word, bit 15 down to bit 0.
  typedef struct packed {
    logic [1:0] rsvd;
    logic       upper_pins_latch_edge;
    logic       lower_pins_latch_edge;
    logic [2:0] bidir_pin_7_mode;
    logic [2:0] bidir_pin_6_mode;
    logic [2:0] bidir_pin_5_mode;
    logic [2:0] bidir_pin_4_mode;
  } tcr_ctrl_b_t;

  // Both control words travel together to the pin logic.
  typedef struct packed {
    tcr_ctrl_a_t a;
    tcr_ctrl_b_t b;
  } tcr_cfg_t;

  localparam tcr_ctrl_a_t CTRL_A_RST = '0;
  localparam tcr_ctrl_b_t CTRL_B_RST = '0;

endpackage : tcr_pkg

// ### tcr_word_mem.sv
// Small word memory holding the plain read-write registers of the map.
// Assumes one write and one read per cycle on the same clock.
module tcr_word_mem
  import tcr_pkg::*;
#(
  parameter int DW = DATA_W,
  parameter int AW = ADDR_W
) (
  // Clock.
  input  wire logic          clk,
  // Write side.
  input  wire logic          we,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [DW-1:0] wdata,
  // Read side, data registered.
  input  wire logic          re,
  input  wire logic [AW-1:0] raddr,
  output logic      [DW-1:0] rdata_reg
);

  // Storage has no reset; software must write a word before using it.
  logic [DW-1:0] mem [2**AW];

  // Elaboration check: the storage needs at least one data bit and one address bit.
  if (DW < 1 || AW < 1) begin : g_bad_geom
    $error("tcr_word_mem: bad geometry");
  end

  // Write port.
  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  // Read port; data holds between reads.
  always_ff @(posedge clk) begin
    if (re) begin
      rdata_reg <= mem[raddr];
    end
  end

endmodule : tcr_word_mem

// ### tcr_host.sv
// Host model: a processor issuing word reads and writes to the bank.
// Assumes the bench calls its tasks; inputs change on falling edges.
module tcr_host
  import tcr_pkg::*;
(
  // Clock.
  input  wire logic              clk,
  // Transaction port towards the bank.
  output logic                   reg_rd,
  output logic                   reg_wr,
  output logic      [ADDR_W-1:0] reg_addr,
  output logic      [DATA_W-1:0] reg_wdata,
  input  wire logic [DATA_W-1:0] reg_rdata,
  input  wire logic              reg_rvalid
);
  timeunit 1ns;
  timeprecision 1ps;

  // Idle bus at time zero.
  initial begin
    reg_rd    = 1'b0;
    reg_wr    = 1'b0;
    reg_addr  = 5'h00;
    reg_wdata = 16'h0000;
  end

  // One write strobe; released lines show the inverse of their last value
  // so that a stale address or word is never mistaken for a live one.
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(negedge clk);
    reg_wr    = 1'b1;
    reg_addr  = a;
    reg_wdata = d;
    @(negedge clk);
    reg_wr    = 1'b0;
    reg_addr  = ~a;
    reg_wdata = ~d;
  endtask : wr

  // One read strobe, then a bounded wait for the answer pulse.
  task automatic rd(input logic [4:0] a, output logic [15:0] d,
                    output bit ok);
    ok = 1'b0;
    d  = 16'h0000;
    @(negedge clk);
    reg_rd   = 1'b1;
    reg_addr = a;
    @(negedge clk);
    reg_rd   = 1'b0;
    reg_addr = ~a;
    for (int i = 0; i < 8 && !ok; i++) begin
      @(negedge clk);
      if (reg_rvalid === 1'b1) begin
        d  = reg_rdata;
        ok = 1'b1;
      end
    end
  endtask : rd
endmodule : tcr_host

// ### tcr_regbank_bench.sv
// Self-checking bench for the control register bank.
// Assumes the host model file is compiled first.
module tcr_regbank_bench
  import tcr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  localparam logic [3:0]  SILICON_REVISION  = 4'h3;   // Arbitrary value.
  localparam logic [11:0] CODE = 12'h2c7; // Arbitrary value.
  localparam logic [6:0]  LL_MASK = 7'h40; // Pin 7 latches low.

  logic              clk = 1'b0;       // 250 MHz clock.
  logic              reset_n = 1'b0;   // Async reset, active low.
  logic              reg_rd;           // Read strobe from the host.
  logic              reg_wr;           // Write strobe from the host.
  logic [ADDR_W-1:0] reg_addr;         // Word address.
  logic [DATA_W-1:0] reg_wdata;        // Write word.
  logic [DATA_W-1:0] reg_rdata;        // Read answer.
  logic              reg_rvalid;       // Answer marker.
  logic [6:0]        pin_in = 7'h77;   // Pin 4 low, others high.
  logic              strap = 1'b1;     // Output pin a strapped high.
  tcr_cfg_t          pin_cfg;          // Control words to the pins.
  logic              soft_reset;       // Global reset pulse.
  int                errors = 0;       // Mismatch count.
  int                cmp_count = 0;    // Comparison count.
  int                sr_seen = 0;      // Soft reset cycles observed.

  always #2 clk = ~clk;

  // Count soft reset cycles so the pulse length can be judged.
  always @(posedge clk) begin
    if (soft_reset === 1'b1) begin
      sr_seen++;
    end
  end

  tcr_host tcr_host_i (.clk(clk), .reg_rd(reg_rd), .reg_wr(reg_wr),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid));

  tcr_regbank #(.SILICON_REV(SILICON_REVISION), .DEVICE_CODE(CODE),
    .LATCH_LOW_MASK(LL_MASK)) tcr_regbank_i (
    .clk(clk), .reset_n(reset_n), .reg_rd(reg_rd), .reg_wr(reg_wr),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .pin_in(pin_in), .out_pin_a_strap(strap),
    .pin_cfg(pin_cfg), .soft_reset(soft_reset));

  // Print the counts and the verdict, then stop.
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : conclude

  // Compare one result word with its expectation.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Read a word and compare it; a missing answer ends the run.
  task automatic rd_chk(input logic [4:0] a, input logic [15:0] e);
    logic [15:0] d;
    bit          ok;
    tcr_host_i.rd(a, d, ok);
    if (!ok) begin
      errors++;
      $display("ERROR %0t no read answer", $time);
      conclude();
    end else begin
      chk({16'h0000, d}, {16'h0000, e});
    end
  endtask : rd_chk

  // Values after reset, with the strap high.
  task automatic t_reset();
    rd_chk(ADDR_PART_SIG, {SILICON_REVISION, CODE});
    rd_chk(ADDR_CTRL_A, 16'h0100);
    rd_chk(ADDR_CTRL_B, 16'h0000);
    chk(pin_cfg, 32'h0100_0000);
    $display("test reset done");
  endtask : t_reset

  // Mode fields read back; read-only places refuse writes.
  task automatic t_fields();
    tcr_host_i.wr(ADDR_CTRL_A, 16'h7fff);
    tcr_host_i.wr(ADDR_CTRL_B, 16'h3fff);
    tcr_host_i.wr(5'h1f, 16'h0000);
    tcr_host_i.wr(ADDR_PART_SIG, 16'hffff);
    tcr_host_i.wr(ADDR_PIN_STAT, 16'hffff);
    rd_chk(ADDR_CTRL_A, 16'h7fff);
    rd_chk(ADDR_CTRL_B, 16'h3fff);
    rd_chk(ADDR_PART_SIG, {SILICON_REVISION, CODE});
    chk(pin_cfg, 32'h7fff_3fff);
    tcr_host_i.wr(ADDR_CTRL_B, 16'hc000);
    rd_chk(ADDR_CTRL_B, 16'h0000);
    $display("test fields done");
  endtask : t_fields

  // Plain words keep what is written; owned-elsewhere words read zero.
  task automatic t_words();
    tcr_host_i.wr(ADDR_EV_MASK, 16'h5a3c);
    tcr_host_i.wr(ADDR_CORE_CFG3, 16'hc3a5);
    rd_chk(ADDR_EV_MASK, 16'h5a3c);
    rd_chk(ADDR_CORE_CFG3, 16'hc3a5);
    rd_chk(ADDR_EV_LATCH, 16'h0000);
    rd_chk(5'h1f, 16'h0000);
    $display("test words done");
  endtask : t_words

  // The reset bit fires one pulse, clears itself and resets the controls.
  task automatic t_softrst();
    tcr_host_i.wr(ADDR_CTRL_A, 16'h7e00);
    tcr_host_i.wr(ADDR_CTRL_B, 16'h2abc);
    sr_seen = 0;
    tcr_host_i.wr(ADDR_CTRL_A, 16'h8000);
    repeat (4) @(negedge clk);
    chk(sr_seen, 32'd1);
    rd_chk(ADDR_CTRL_A, 16'h0100);
    rd_chk(ADDR_CTRL_B, 16'h0000);
    $display("test soft reset done");
  endtask : t_softrst

  // Edge selection per group; latched bits clear on read.
  task automatic t_pins();
    logic [15:0] d;
    bit          ok;
    tcr_host_i.wr(ADDR_CTRL_B, 16'h2000);
    tcr_host_i.rd(ADDR_PIN_STAT, d, ok);
    // Pin 1 falls, pin 4 rises, pin 5 falls against its rising select.
    // Pin 7 is latch-low, so its latched bit reads one while idle.
    @(negedge clk);
    pin_in = 7'h6e;
    repeat (6) @(negedge clk);
    rd_chk(ADDR_PIN_STAT, 16'h496e);
    rd_chk(ADDR_PIN_STAT, 16'h406e);
    // Swap both selects; pin 1 rises now latches, pin 4 falls too.
    tcr_host_i.wr(ADDR_CTRL_B, 16'h1000);
    @(negedge clk);
    pin_in = 7'h67;
    repeat (6) @(negedge clk);
    rd_chk(ADDR_PIN_STAT, 16'h4967);
    rd_chk(ADDR_PIN_STAT, 16'h4067);
    // Pin 7 falls with the falling select: its latch-low bit drops.
    @(negedge clk);
    pin_in = 7'h27;
    repeat (6) @(negedge clk);
    rd_chk(ADDR_PIN_STAT, 16'h0027);
    rd_chk(ADDR_PIN_STAT, 16'h4027);
    $display("test pins done");
  endtask : t_pins

  // A second reset with the strap low leaves pin 1 at high impedance.
  task automatic t_strap_low();
    @(negedge clk);
    strap   = 1'b0;
    reset_n = 1'b0;
    repeat (4) @(negedge clk);
    chk(pin_cfg, 32'h0000_0000);
    reset_n = 1'b1;
    repeat (8) @(negedge clk);
    rd_chk(ADDR_CTRL_A, 16'h0000);
    tcr_host_i.wr(ADDR_CTRL_A, 16'h8000);
    repeat (4) @(negedge clk);
    rd_chk(ADDR_CTRL_A, 16'h0000);
    $display("test strap low done");
  endtask : t_strap_low

  // Main sequence: reset for 20 cycles, let the strap settle, run tests.
  initial begin
    repeat (20) @(negedge clk);
    reset_n = 1'b1;
    repeat (8) @(negedge clk);
    t_reset();
    t_fields();
    t_words();
    t_softrst();
    t_pins();
    t_strap_low();
    conclude();
  end
endmodule : tcr_regbank_bench
